/* File: hdl/pdi_deadtime_top.sv */
// The implementer's own choice: the APB register port.
`timescale 1ns/100ps
`include "pdi_consts.svh"
// Functional notes
// RL1: Dead-time clock is oscillator over 2..16
// RL2: Low six bits give unsigned count
// RL3: Edge bit 1 falling, 0 rising
// RL4: Edge bits 4..7 map pairs 0..3
// RL5: Enabled pair delays low-to-high changes
// RL6: Enable bits 0..3 map pairs 0..3
// RL7: Insertion only in complementary mode
// RL8: Inactive insertion gives exact complements
// RL9: Edge and enable nibbles reset zero
// RL10: Held output low until count expires
// RL11: Output-mode bits gate channels to pins
// RL12: Brake pin sets flag, software clears
// RL13: Output-mode bits clear on reset
// RL14: Brake forces outputs to level bits
module pdi_deadtime_top import pdi_pkg::*; (
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [9:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Channel levels and modes from the PWM core
  input  wire logic [7:0]  PWM_IN,
  input  wire logic [3:0]  COMP_MODE,
  // External brake pin
  input  wire logic        BRAKE_PIN,
  // PWM pins
  output logic      [7:0]  PWM_O,
  output logic      [7:0]  PWM_OE,
  // Interrupt
  output logic             IRQ
);
  localparam int NP = `PDI_NUM_PAIRS;

  // Software-visible state
  logic [7:0]            dt_psc_cnt;
  logic [7:0]            dt_edge_en;
  logic [3:0]            out_mode;
  logic                  brake_pin_flag;
  logic [7:0]            brake_lvl;
  logic [`PDI_IRQ_W-1:0] irq_status;
  logic [`PDI_IRQ_W-1:0] irq_mask;

  // Brake pin synchroniser
  logic                  brk_s1;
  logic                  brk_s2;
  logic                  brk_q;

  // Per-pair results
  pdi_pair_t             pair_ctl [NP];
  logic [NP-1:0]         lvl_even;
  logic [NP-1:0]         lvl_odd;
  logic [NP-1:0]         dt_done;
  logic [7:0]            chan_lvl;

  // Bus request bundle
  pdi_apb_req_t          req;
  assign req = '{psel:    PSEL,
                 penable: PENABLE,
                 pwrite:  PWRITE,
                 paddr:   PADDR,
                 pwdata:  PWDATA};

  // Address decode; low address bits ignored, word aligned
  wire [7:0] idx      = req.paddr[9:2];
  wire       hit_psc  = (idx == `PDI_IDX_DT_PSC_CNT);
  wire       hit_edge = (idx == `PDI_IDX_DT_EDGE_EN);
  wire       hit_out  = (idx == `PDI_IDX_OUT_BRAKE);
  wire       hit_lvl  = (idx == `PDI_IDX_BRAKE_LVL);
  wire       hit_stat = (idx == `PDI_IDX_IRQ_STAT);
  wire       hit_mask = (idx == `PDI_IDX_IRQ_MASK);
  wire       mapped   = hit_psc | hit_edge | hit_out |
                        hit_lvl | hit_stat | hit_mask;

  // Transfer phases; a write lands only at the completing edge
  wire       setup    = req.psel & ~req.penable;
  wire       commit   = req.psel & req.penable & PREADY;
  wire       wr       = commit & req.pwrite & mapped;
  wire       wr_psc   = wr & hit_psc;
  wire       wr_edge  = wr & hit_edge;
  wire       wr_out   = wr & hit_out;
  wire       wr_lvl   = wr & hit_lvl;
  wire       wr_mask  = wr & hit_mask;
  wire       rd_clr   = commit & ~req.pwrite & hit_stat;

  // Output and brake register as software sees it
  wire [7:0] out_view = {out_mode, 3'b000, brake_pin_flag};

  // Read selection
  wire [7:0] rd_mux =
      ({8{hit_psc}}  & dt_psc_cnt)
    | ({8{hit_edge}} & dt_edge_en)
    | ({8{hit_out}}  & out_view)
    | ({8{hit_lvl}}  & brake_lvl)
    | ({8{hit_stat}} & {3'b000, irq_status})
    | ({8{hit_mask}} & {3'b000, irq_mask});

  // Writing 0 to bit 0 of the output register clears the brake flag
  wire bkf_clr = wr_out & ~req.pwdata[`PDI_BKF]; // RL12

  // Events feeding the sticky status bits
  wire       brake_rise = brk_s2 & ~brk_q;
  wire [`PDI_IRQ_W-1:0] events = {dt_done, brake_rise};

  // Only bits actually returned are cleared, so a later event survives
  wire [`PDI_IRQ_W-1:0] stat_clr =
      rd_clr ? PRDATA[`PDI_IRQ_W-1:0] : '0;

  // Dead-time timing shared by all pairs
  wire pdi_dt_cfg_t dt_cfg = '{
      psc: dt_psc_cnt[`PDI_PSC_MSB:`PDI_PSC_LSB], // RL1
      cnt: dt_psc_cnt[`PDI_CNT_MSB:0]};            // RL2

  // Channel to output-mode bit map
  wire om_even  = out_mode[3];
  wire om_odd   = out_mode[2];
  wire om_six   = out_mode[1];
  wire om_seven = out_mode[0];
  wire [7:0] om_ch = {om_seven, om_six,  // RL11
                      om_odd, om_even,
                      om_odd, om_even,
                      om_odd, om_even};

  // APB answer: ready one cycle after setup, no further wait states
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else begin
      PREADY  <= setup;
      PSLVERR <= setup & ~mapped;
      PRDATA  <= setup ? {24'h00_0000, rd_mux} : 32'h0000_0000;
    end
  end

  // Dead-time prescale and count register
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      dt_psc_cnt <= `PDI_RST_DT_PSC_CNT;
    end else if (wr_psc) begin
      dt_psc_cnt <= req.pwdata[7:0];
    end
  end

  // Edge-select and enable nibbles, both zero after reset
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      dt_edge_en <= `PDI_RST_DT_EDGE_EN; // RL9
    end else if (wr_edge) begin
      dt_edge_en <= req.pwdata[7:0];
    end
  end

  // Output-mode bits; cleared so shared pins float after reset
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      out_mode <= `PDI_RST_OUT_MODE; // RL13
    end else if (wr_out) begin
      out_mode <= req.pwdata[`PDI_OM_EVEN:`PDI_OM_SEVEN];
    end
  end

  // Brake flag: hardware sets, software writes 0 to clear, set wins
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      brake_pin_flag <= 1'b0;
    end else begin
      brake_pin_flag <= brk_s2 | (brake_pin_flag & ~bkf_clr); // RL12
    end
  end

  // Brake level bits
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      brake_lvl <= `PDI_RST_BRAKE_LVL;
    end else if (wr_lvl) begin
      brake_lvl <= req.pwdata[7:0];
    end
  end

  // Interrupt mask
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_mask <= `PDI_RST_IRQ;
    end else if (wr_mask) begin
      irq_mask <= req.pwdata[`PDI_IRQ_W-1:0];
    end
  end

  // Sticky status, cleared by read; a same-cycle event wins
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_status <= `PDI_RST_IRQ;
    end else begin
      irq_status <= (irq_status & ~stat_clr) | events;
    end
  end

  // Brake pin crosses in from outside through two flops
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      brk_s1 <= 1'b0;
      brk_s2 <= 1'b0;
      brk_q  <= 1'b0;
    end else begin
      brk_s1 <= BRAKE_PIN;
      brk_s2 <= brk_s1;
      brk_q  <= brk_s2;
    end
  end

  // One dead-time unit per complementary pair
  genvar gp;
  generate
    for (gp = 0; gp < NP; gp++) begin : g_pair
      // Edge bits from bit 4 upward, enable bits from bit 0
      assign pair_ctl[gp] = '{
          comp:      COMP_MODE[gp],                  // RL7
          edge_fall: dt_edge_en[`PDI_EDGE_LSB + gp], // RL4
          ins_en:    dt_edge_en[`PDI_EN_LSB + gp]};  // RL6

      pdi_pair_unit u_pair (
        .clk      (REF_CLK),
        .rst_n    (RST_N),
        .cfg      (dt_cfg),
        .ctl      (pair_ctl[gp]),
        .sig      (PWM_IN[2*gp]),
        .even_lvl (lvl_even[gp]),
        .odd_lvl  (lvl_odd[gp]),
        .done     (dt_done[gp])
      );

      // Independent channels pass straight through
      assign chan_lvl[2*gp]   = COMP_MODE[gp] ? lvl_even[gp]
                                              : PWM_IN[2*gp];
      assign chan_lvl[2*gp+1] = COMP_MODE[gp] ? lvl_odd[gp]
                                              : PWM_IN[2*gp+1];
    end
  endgenerate

  // Pin stage; brake overrides whatever the channels want
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PWM_O  <= 8'h00;
      PWM_OE <= 8'h00;
      IRQ    <= 1'b0;
    end else begin
      PWM_O  <= brk_s2 ? brake_lvl : chan_lvl; // RL14
      PWM_OE <= om_ch; // RL11
      IRQ    <= |(irq_status & irq_mask);
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  AST_BRAKE_FORCE: assert property ( // RL14
    brk_s2 |=> PWM_O == $past(brake_lvl))
    else $error("Brake level not forced on pins");
  AST_EVEN_OFF: assert property ( // RL11
    !out_mode[3] |=> !PWM_OE[0] && !PWM_OE[2] && !PWM_OE[4])
    else $error("Even channel driven while disabled");
  AST_ODD_ON: assert property ( // RL11
    out_mode[2] |=> PWM_OE[1] && PWM_OE[3] && PWM_OE[5])
    else $error("Odd channel not driven while enabled");
  AST_BKF_SET: assert property ( // RL12
    $rose(BRAKE_PIN) ##2 1'b1 |=> brake_pin_flag)
    else $error("Brake flag not set by pin");
  AST_BKF_KEEP: assert property ( // RL12
    brake_pin_flag && !bkf_clr |=> brake_pin_flag)
    else $error("Brake flag lost without software");
  AST_PASS: assert property ( // RL7
    !COMP_MODE[0] && !brk_s2 |=> PWM_O[1:0] == $past(PWM_IN[1:0]))
    else $error("Independent channel altered");
  AST_READY: assert property (
    setup |=> PREADY ##1 !PREADY)
    else $error("Ready not one cycle after setup");
  AST_UNMAPPED: assert property (
    setup && !mapped |=> PSLVERR && PRDATA == 32'h0000_0000)
    else $error("Unmapped access not refused");
  AST_IRQ: assert property (
    (irq_status & irq_mask) != '0 |=> IRQ)
    else $error("Interrupt missing for unmasked event");
  AST_STICKY: assert property (
    events[0] |=> irq_status[0])
    else $error("Brake event not recorded");

  CVR_BRAKE: cover property (brake_rise ##[1:20] bkf_clr);
  CVR_CLEAR: cover property (rd_clr && PRDATA[4:0] != 5'h00);
  CVR_DT: cover property (COMP_MODE[0] && dt_edge_en[0] && dt_done[0]);
endmodule // pdi_deadtime_top

/* File: shared/pdi_consts.svh */
`ifndef PDI_CONSTS_SVH
`define PDI_CONSTS_SVH
// Register indices; byte address is four times the index
`define PDI_IDX_DT_PSC_CNT 8'hE5
`define PDI_IDX_DT_EDGE_EN 8'hE6
`define PDI_IDX_OUT_BRAKE  8'hE7
`define PDI_IDX_BRAKE_LVL  8'hDF
`define PDI_IDX_IRQ_STAT   8'hF0
`define PDI_IDX_IRQ_MASK   8'hF1
// Field positions
`define PDI_PSC_MSB        7
`define PDI_PSC_LSB        6
`define PDI_CNT_MSB        5
`define PDI_EDGE_LSB       4
`define PDI_EN_LSB         0
`define PDI_OM_EVEN        7
`define PDI_OM_ODD         6
`define PDI_OM_SIX         5
`define PDI_OM_SEVEN       4
`define PDI_BKF            0
`define PDI_IRQ_BRAKE      0
`define PDI_IRQ_DT_LSB     1
`define PDI_IRQ_W          5
`define PDI_NUM_PAIRS      4
// Reset values
`define PDI_RST_DT_PSC_CNT 8'h00
`define PDI_RST_DT_EDGE_EN 8'h00
`define PDI_RST_OUT_MODE   4'h0
`define PDI_RST_BRAKE_LVL  8'h00
`define PDI_RST_IRQ        5'h00
`endif

/* File: shared/pdi_pkg.sv */
package pdi_pkg;
  // Dead-time timing taken from the prescale and count register
  typedef struct packed {
    logic [1:0] psc;
    logic [5:0] cnt;
  } pdi_dt_cfg_t;
  // Per-pair control
  typedef struct packed {
    logic comp;
    logic edge_fall;
    logic ins_en;
  } pdi_pair_t;
  // Register bus request
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [9:0]  paddr;
    logic [31:0] pwdata;
  } pdi_apb_req_t;
  // Dead-time unit states
  typedef enum logic [1:0] {
    DT_IDLE = 2'b01,
    DT_HOLD = 2'b10
  } pdi_dt_state_t;
endpackage

/* File: hdl/pdi_pair_unit.sv */
`timescale 1ns/100ps
module pdi_pair_unit import pdi_pkg::*; (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Timing and control
  input  wire pdi_dt_cfg_t cfg,
  input  wire pdi_pair_t   ctl,
  input  wire logic        sig,
  // Pair levels and expiry pulse
  output logic             even_lvl,
  output logic             odd_lvl,
  output logic             done
);
  pdi_dt_state_t state;
  pdi_dt_state_t next_state;
  logic          sig_q;
  logic [3:0]    pcnt;
  logic [3:0]    next_pcnt;
  logic [5:0]    dcnt;
  logic [5:0]    next_dcnt;
  logic [10:0]   hold_len;

  // Edge detect and prescaled tick
  wire       active   = ctl.ins_en & ctl.comp; // RL7
  wire       rise     = sig & ~sig_q;
  wire       fall     = ~sig & sig_q;
  wire       trig     = active & (ctl.edge_fall ? fall : rise); // RL3
  wire [3:0] div_last = 4'((5'd2 << cfg.psc) - 5'd1); // RL1
  wire       p_wrap   = (pcnt == div_last);
  wire       holding  = (state == DT_HOLD);
  wire       expire   = holding & p_wrap & (dcnt == 6'h00) & ~trig;
  wire       hold     = active & (holding | trig); // RL10

  // Held side is always the one about to rise, so no capture needed
  assign even_lvl = sig & ~hold; // RL5 RL8
  assign odd_lvl  = ~sig & ~hold; // RL5 RL8

  // Next state; a selected edge restarts a running hold, any other edge or loss of enable aborts it
  always_comb begin
    next_state = state;
    next_pcnt  = pcnt;
    next_dcnt  = dcnt;
    case (state)
      DT_IDLE: begin
        if (trig) begin
          next_state = DT_HOLD;
          next_pcnt  = 4'h1;
          next_dcnt  = cfg.cnt; // RL2
        end
      end
      DT_HOLD: begin
        if (trig) begin
          next_pcnt = 4'h1;
          next_dcnt = cfg.cnt;
        end else if (!active || rise || fall || expire) begin
          next_state = DT_IDLE; // RL10
        end else if (p_wrap) begin
          next_pcnt = 4'h0;
          next_dcnt = dcnt - 6'h01;
        end else begin
          next_pcnt = pcnt + 4'h1;
        end
      end
      default: next_state = DT_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= DT_IDLE;
      sig_q <= 1'b0;
      pcnt  <= 4'h0;
      dcnt  <= 6'h00;
      done  <= 1'b0;
    end else begin
      state <= next_state;
      sig_q <= sig;
      pcnt  <= next_pcnt;
      dcnt  <= next_dcnt;
      done  <= expire;
    end
  end

  // Length of the current hold, checked against the programmed figure
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_len <= 11'h000;
    end else begin
      if (trig) begin
        hold_len <= 11'h001; // A retrigger starts a fresh hold
      end else begin
        hold_len <= hold ? hold_len + 11'h001 : 11'h000;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_HOLD_LEN: assert property ( // RL1
    done && $stable(cfg) |->
      hold_len == 11'(({5'h00, cfg.cnt} + 11'h001) <<
                      ({1'b0, cfg.psc} + 3'd1)))
    else $error("Dead-time length wrong");
  AST_PLAIN: assert property ( // RL8
    !active |-> even_lvl == sig && odd_lvl == !sig)
    else $error("Pair not plain complement");
  AST_RISE_HOLD: assert property ( // RL3
    trig && !ctl.edge_fall |-> !even_lvl && !odd_lvl)
    else $error("Rising edge not held");
  AST_FALL_HOLD: assert property ( // RL5
    active && ctl.edge_fall && fall |-> !odd_lvl ##1 (!odd_lvl || !active))
    else $error("Falling edge not held");
  CVR_DONE: cover property (done);
endmodule // pdi_pair_unit

/* File: sim/pdi_sw_drv_model.sv */
`timescale 1ns/100ps
module pdi_sw_drv_model (
  // Clock
  input  wire logic       clk,
  // Gate lines from the block
  input  wire logic [7:0] pwm_o,
  input  wire logic [7:0] pwm_oe,
  // Cycles with both switches of a leg on
  output int              shoot_cnt
);
  logic [7:0] gate;

  // Undriven gate lines sit at the driver's pull-down level
  assign gate = pwm_o & pwm_oe;

  // Both switches of a leg on at once would short the rail
  initial shoot_cnt = 0;
  always @(posedge clk) begin
    for (int p = 0; p < 4; p++) begin
      if (gate[2*p] && gate[2*p+1]) begin
        shoot_cnt <= shoot_cnt + 1;
      end
    end
  end
endmodule // pdi_sw_drv_model

/* File: sim/tb_top.sv */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    failures++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); \
  end \
end
module tb_top;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        brake_pin, irq;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  pwm_in, pwm_o, pwm_oe;
  logic [3:0]  comp_mode;
  int          failures, checks_done, shoot_cnt;

  // Block under test and the switch drivers it feeds
  pdi_deadtime_top i_dut (
    .REF_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .PWM_IN(pwm_in),
    .COMP_MODE(comp_mode), .BRAKE_PIN(brake_pin), .PWM_O(pwm_o),
    .PWM_OE(pwm_oe), .IRQ(irq));
  pdi_sw_drv_model i_drv (.clk(clk), .pwm_o(pwm_o), .pwm_oe(pwm_oe),
    .shoot_cnt(shoot_cnt));

  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic stop_test();
    $display("failures %0d checks_done %0d", failures, checks_done);
    if (failures == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic wait_n(int n);
    repeat (n) @(negedge clk);
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [7:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h0000_00, wd};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [31:0] d;
    logic        e;
    apb(1'b1, idx, wd, d, e);
  endtask

  task automatic rchk(string nm, logic [7:0] idx, logic [31:0] exp);
    logic [31:0] d;
    logic        e;
    apb(1'b0, idx, 8'h00, d, e);
    `CHK(nm, exp, d)
  endtask

  // Delayed channel must rise hold+2 negedges after the reference edge
  task automatic meas(int p, int e, int hold);
    int          n;
    logic [31:0] d;
    logic        er;
    @(posedge clk);
    pwm_in[2*p] <= e[0];
    wait_n(20);
    apb(1'b0, 8'hF0, 8'h00, d, er);
    @(posedge clk);
    pwm_in[2*p] <= ~e[0];
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (n == 2) `CHK("lead side", 1'b0, pwm_o[2*p+1-e])
    end while (pwm_o[2*p+e] !== 1'b1 && n < 1200);
    `CHK("dead time", hold + 2, n)
  endtask

  // Main sequence
  initial begin
    logic [31:0] d;
    logic        er;
    logic [7:0]  v, x;
    logic [7:0]  om_exp [4] = '{8'h15, 8'h2A, 8'h40, 8'h80};
    logic [7:0]  regs [4] = '{8'hE5, 8'hE6, 8'hDF, 8'hF1};
    int          p, e, c, psc;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {pwm_in, comp_mode, brake_pin, rst_n} = '0;
    failures = 0;
    checks_done = 0;
    void'($urandom(39675));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    `CHK("oe reset", 8'h00, pwm_oe)
    rchk("edge enable", 8'hE6, 32'h0);
    rchk("out ctrl", 8'hE7, 32'h0);
    for (int k = 0; k < 4; k++) begin
      v = 8'($urandom);
      wr(regs[k], v);
      x = (regs[k] == 8'hF1) ? (v & 8'h1F) : v; // Mask is five bits
      rchk("reg rw", regs[k], {24'h0000_00, x});
    end
    apb(1'b0, 8'h10, 8'h00, d, er);
    `CHK("unmapped err", 1'b1, er)
    for (int k = 0; k < 4; k++) begin
      wr(8'hE7, 8'h80 >> k);
      wait_n(3);
      `CHK("oe map", om_exp[k], pwm_oe)
    end
    // Insertion off: exact complements one cycle later
    wr(8'hE6, 8'h00);
    wr(8'hE7, 8'hF0);
    comp_mode <= 4'hF;
    for (int k = 0; k < 20; k++) begin
      v = 8'($urandom);
      @(posedge clk);
      pwm_in <= v;
      wait_n(2);
      for (int q = 0; q < 4; q++) begin
        x[2*q] = v[2*q];
        x[2*q+1] = ~v[2*q];
      end
      `CHK("complement", x, pwm_o)
    end
    // Every pair, both edges, all prescalers, count up to 63
    wr(8'hF1, 8'h1F);
    for (int i = 0; i < 8; i++) begin
      p = i % 4;
      e = i / 4;
      psc = i / 2;
      c = (i == 7) ? 63 : $urandom_range(5, 0);
      wr(8'hE5, {psc[1:0], c[5:0]});
      wr(8'hE6, 8'((e << (p + 4)) | (1 << p)));
      meas(p, e, (c + 1) << (psc + 1));
      wait_n(3);
      `CHK("irq set", 1'b1, irq)
      rchk("expiry stat", 8'hF0, 32'(1 << (p + 1)));
      wait_n(3);
      `CHK("irq clear", 1'b0, irq)
    end
    `CHK("overlap", 0, shoot_cnt)
    // Pair not complementary: enable bit has no effect
    wr(8'hE6, 8'h01);
    @(posedge clk);
    comp_mode <= 4'hE;
    pwm_in[1] <= 1'b0;
    meas(0, 0, 0);
    // Brake forces levels; flag stays until software clears it
    wr(8'hF1, 8'h00);
    apb(1'b0, 8'hF0, 8'h00, d, er);
    v = 8'($urandom);
    wr(8'hDF, v);
    @(posedge clk);
    brake_pin <= 1'b1;
    wait_n(6);
    `CHK("brake level", v, pwm_o)
    `CHK("irq masked", 1'b0, irq)
    rchk("flag set", 8'hE7, 32'h0000_00F1);
    @(posedge clk);
    brake_pin <= 1'b0;
    wait_n(6);
    rchk("flag sticky", 8'hE7, 32'h0000_00F1);
    wr(8'hF1, 8'h01);
    wait_n(3);
    `CHK("irq brake", 1'b1, irq)
    rchk("brake stat", 8'hF0, 32'h0000_0001);
    wr(8'hE7, 8'hF0);
    rchk("flag clear", 8'hE7, 32'h0000_00F0);
    stop_test();
  end

  // Watchdog well beyond the longest expected run
  initial begin
    #(8 * 20000);
    failures++;
    stop_test();
  end
endmodule // tb_top
